//--- rtl/bmsd_regs.vh
`ifndef BMSD_REGS_VH
`define BMSD_REGS_VH
`define BMSD_ADDR_CTRL      12'h000
`define BMSD_ADDR_STATUS    12'h004
`define BMSD_ADDR_MATCH     12'h008
`define BMSD_ADDR_MASTER    12'h00c
`define BMSD_ADDR_BE        12'h010
`define BMSD_ADDR_WDATA     12'h014
`define BMSD_ADDR_LANES     12'h018
`define BMSD_ADDR_HITCNT    12'h01c
`define BMSD_CTRL_BRD_BIT   0
`define BMSD_CTRL_BWR_BIT   1
`define BMSD_CTRL_GO_BIT    2
`define BMSD_CTRL_WR_BIT    3
`define BMSD_CTRL_MIO_BIT   4
`define BMSD_CTRL_RST       32'h0000_0003
`define BMSD_MATCH_RST      30'h0000_0000
`define BMSD_BE_RST         4'hf
`endif

//--- rtl/bmsd_lane_dup.v
`timescale 1ns/1ps
module bmsd_lane_dup (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire [3:0]  be_n_i,
  input  wire [31:0] data_i,
  output reg  [31:0] data_o
);
  // Copy active bytes onto the unused half
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      data_o <= 32'h0000_0000;
    end else begin
      data_o <= data_i;
      if (be_n_i[3:2] == 2'b11) begin
        data_o[31:16] <= data_i[15:0];
      end else if (be_n_i[1:0] == 2'b11) begin
        data_o[15:0] <= data_i[31:16];
      end
    end
  end
endmodule // bmsd_lane_dup

//--- rtl/bmsd_top.v
`timescale 1ns/1ps
`include "bmsd_regs.vh"
// Operation
// - Test select 1 gives test port, 0 gives four interrupts and chain.
// - Test select remaps shared pins through a two-flop synchroniser and clocked register, held at defaults in reset.
// - Interrupt mode: clock/out become chain grant/request, in/mode become irq 3/4.
// - Bus-mode strap high gives generic 486 bus, low gives VL-Bus.
// - Generic mode renames burst, reset, size, request, grant, chain pins.
// - Burst-permit strap sampled every clock edge while reset is asserted.
// - VL-Bus with sampled permit low forces burst enables to zero.
// - VL-Bus with permit high bursts only as enable bits allow.
// - Driven data always duplicated into correct byte lanes in both modes.
// - Strap table: 4 or 2 interrupts; generic with permit high reserved.
// - Drive address lines as master, otherwise monitor them for slave match.
// - On address status low decode cycle type and address for a hit.
// - Drive address status low at start of each own master access.
// - Byte enables 3..0 mark the four data bytes; driven as master.
// - Respond only to data cycles; drive data/control high as master.
// - Byte and word transfers copy active bytes onto the unused half.
module bmsd_top (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        test_port_select_strap_i,
  input  wire        bus_mode_strap_i,
  input  wire        burst_permit_strap_i,
  input  wire        tck_pin_i,
  input  wire        tdo_src_i,
  input  wire        tdi_pin_i,
  input  wire        tms_pin_i,
  input  wire        chain_grant_src_i,
  input  wire        irq_three_src_i,
  input  wire        irq_four_src_i,
  input  wire        bus_grant_in_i,
  input  wire [29:0] address_lines_i,
  input  wire        address_status_n_i,
  input  wire        mem_io_i,
  input  wire        data_ctrl_i,
  input  wire        write_read_i,
  input  wire [3:0]  byte_lane_enables_i,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         test_mode_o,
  output reg         generic_bus_o,
  output reg         reserved_cfg_o,
  output reg         tck_o,
  output reg         tck_oe_n_o,
  output reg         tdo_o,
  output reg         tdo_oe_n_o,
  output reg         tdi_o,
  output reg         tdi_oe_n_o,
  output reg         tms_o,
  output reg         tms_oe_n_o,
  output reg         chain_request_in_o,
  output reg         tck_in_o,
  output reg         tdi_in_o,
  output reg         tms_in_o,
  output reg         burst_read_enable_o,
  output reg         burst_write_enable_o,
  output reg         bus_request_out_o,
  output reg  [29:0] address_lines_o,
  output reg         address_lines_oe_n_o,
  output reg         address_status_n_o,
  output reg         address_status_oe_n_o,
  output reg         mem_io_o,
  output reg         data_ctrl_o,
  output reg         write_read_o,
  output reg         cycle_def_oe_n_o,
  output reg  [3:0]  byte_lane_enables_o,
  output reg  [3:0]  byte_lane_enables_oe_n_o,
  output wire [31:0] data_lines_o,
  output reg         data_lines_oe_n_o,
  output reg         slave_hit_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_REQ  = 2'd1;
  localparam ST_ADDR = 2'd2;
  localparam ST_DATA = 2'd3;

  reg        tsel_s1_q;
  reg        tsel_q;
  reg        bmode_s1_q;
  reg        bmode_q;
  reg        grant_s1_q;
  reg        grant_q;
  reg        permit_q;
  reg [31:0] ctrl_q;
  reg [29:0] match_q;
  reg [29:0] master_addr_q;
  reg [3:0]  be_q;
  reg [31:0] wdata_q;
  reg [15:0] hit_cnt_q;
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg        go_q;
  reg        hit_d;
  reg [31:0] rdata_d;
  wire       is_master;
  wire       wr_acc;
  wire       rd_acc;
  wire       brd_eff;
  wire       bwr_eff;

  assign wr_acc    = psel & penable & pwrite & pready;
  assign rd_acc    = psel & penable & ~pwrite & ~pready;
  assign is_master = (state_q == ST_ADDR) || (state_q == ST_DATA);

  // Burst gating by sampled permit in VL-Bus mode
  assign brd_eff = ctrl_q[`BMSD_CTRL_BRD_BIT] & (bmode_q | permit_q);
  assign bwr_eff = ctrl_q[`BMSD_CTRL_BWR_BIT] & (bmode_q | permit_q);

  // Strap and bus grant synchronisers
  always @(posedge clk_sys_i) begin
    tsel_s1_q  <= test_port_select_strap_i;
    tsel_q     <= tsel_s1_q;
    bmode_s1_q <= bus_mode_strap_i;
    bmode_q    <= bmode_s1_q;
    grant_s1_q <= bus_grant_in_i;
    grant_q    <= grant_s1_q;
  end

  // Permit strap captured while reset held
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      permit_q <= burst_permit_strap_i;
    end
  end

  // Pin function mux for the shared test/irq/chain pins
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tck_o              <= 1'b1;
      tck_oe_n_o         <= 1'b1;
      tdo_o              <= 1'b0;
      tdo_oe_n_o         <= 1'b1;
      tdi_o              <= 1'b0;
      tdi_oe_n_o         <= 1'b1;
      tms_o              <= 1'b0;
      tms_oe_n_o         <= 1'b1;
      chain_request_in_o <= 1'b0;
      tck_in_o           <= 1'b0;
      tdi_in_o           <= 1'b0;
      tms_in_o           <= 1'b0;
      test_mode_o        <= 1'b0;
      generic_bus_o      <= 1'b0;
      reserved_cfg_o     <= 1'b0;
    end else begin
      test_mode_o    <= tsel_q;
      generic_bus_o  <= bmode_q;
      reserved_cfg_o <= bmode_q & permit_q;
      if (tsel_q) begin
        tck_oe_n_o         <= 1'b1;
        tdo_o              <= tdo_src_i;
        tdo_oe_n_o         <= 1'b0;
        tdi_oe_n_o         <= 1'b1;
        tms_oe_n_o         <= 1'b1;
        tck_in_o           <= tck_pin_i;
        tdi_in_o           <= tdi_pin_i;
        tms_in_o           <= tms_pin_i;
        chain_request_in_o <= 1'b0;
      end else begin
        tck_o              <= chain_grant_src_i;
        tck_oe_n_o         <= 1'b0;
        tdo_oe_n_o         <= 1'b1;
        chain_request_in_o <= tdo_src_i;
        tdi_o              <= irq_three_src_i;
        tdi_oe_n_o         <= 1'b0;
        tms_o              <= irq_four_src_i;
        tms_oe_n_o         <= 1'b0;
        tck_in_o           <= 1'b0;
        tdi_in_o           <= 1'b0;
        tms_in_o           <= 1'b0;
      end
    end
  end

  // Slave address decode
  always @* begin
    hit_d = ~address_status_n_i & ~mem_io_i & data_ctrl_i & (address_lines_i == match_q) & ~is_master;
  end

  // Master state machine
  always @* begin
    case (state_q)
      ST_IDLE: begin
        state_d = go_q ? ST_REQ : ST_IDLE;
      end
      ST_REQ: begin
        state_d = grant_q ? ST_ADDR : ST_REQ;
      end
      ST_ADDR: begin
        state_d = ST_DATA;
      end
      ST_DATA: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q                  <= ST_IDLE;
      go_q                     <= 1'b0;
      bus_request_out_o        <= 1'b0;
      address_lines_o          <= 30'h0000_0000;
      address_lines_oe_n_o     <= 1'b1;
      address_status_n_o       <= 1'b1;
      address_status_oe_n_o    <= 1'b1;
      mem_io_o                 <= 1'b0;
      data_ctrl_o              <= 1'b1;
      write_read_o             <= 1'b0;
      cycle_def_oe_n_o         <= 1'b1;
      byte_lane_enables_o      <= `BMSD_BE_RST;
      byte_lane_enables_oe_n_o <= 4'hf;
      data_lines_oe_n_o        <= 1'b1;
      slave_hit_o              <= 1'b0;
      hit_cnt_q                <= 16'h0000;
    end else begin
      state_q     <= state_d;
      slave_hit_o <= hit_d;
      if (hit_d) begin
        hit_cnt_q <= hit_cnt_q + 16'h0001;
      end
      if (wr_acc && paddr == `BMSD_ADDR_CTRL && pwdata[`BMSD_CTRL_GO_BIT]) begin
        go_q <= 1'b1;
      end else if (state_q == ST_IDLE) begin
        go_q <= 1'b0;
      end
      bus_request_out_o        <= (state_d == ST_REQ) || (state_d == ST_ADDR) || (state_d == ST_DATA);
      address_lines_o          <= master_addr_q;
      address_lines_oe_n_o     <= ~((state_d == ST_ADDR) || (state_d == ST_DATA));
      address_status_n_o       <= ~(state_d == ST_ADDR);
      address_status_oe_n_o    <= ~((state_d == ST_ADDR) || (state_d == ST_DATA));
      mem_io_o                 <= ctrl_q[`BMSD_CTRL_MIO_BIT];
      data_ctrl_o              <= 1'b1;
      write_read_o             <= ctrl_q[`BMSD_CTRL_WR_BIT];
      cycle_def_oe_n_o         <= ~((state_d == ST_ADDR) || (state_d == ST_DATA));
      byte_lane_enables_o      <= be_q;
      byte_lane_enables_oe_n_o <= {4{~((state_d == ST_ADDR) || (state_d == ST_DATA))}};
      data_lines_oe_n_o        <= ~(ctrl_q[`BMSD_CTRL_WR_BIT] && (state_d == ST_DATA));
    end
  end

  bmsd_lane_dup u_lane_dup (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .be_n_i    (be_q),
    .data_i    (wdata_q),
    .data_o    (data_lines_o)
  );

  // APB register file
  always @* begin
    case (paddr)
      `BMSD_ADDR_CTRL:   rdata_d = {ctrl_q[31:2], bwr_eff, brd_eff};
      `BMSD_ADDR_STATUS: rdata_d = {26'h0000000, state_q, reserved_cfg_o, permit_q, bmode_q, tsel_q};
      `BMSD_ADDR_MATCH:  rdata_d = {match_q, 2'b00};
      `BMSD_ADDR_MASTER: rdata_d = {master_addr_q, 2'b00};
      `BMSD_ADDR_BE:     rdata_d = {28'h0000000, be_q};
      `BMSD_ADDR_WDATA:  rdata_d = wdata_q;
      `BMSD_ADDR_LANES:  rdata_d = data_lines_o;
      `BMSD_ADDR_HITCNT: rdata_d = {16'h0000, hit_cnt_q};
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_q        <= `BMSD_CTRL_RST;
      match_q       <= `BMSD_MATCH_RST;
      master_addr_q <= 30'h0000_0000;
      be_q          <= `BMSD_BE_RST;
      wdata_q       <= 32'h0000_0000;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (rd_acc) begin
        prdata <= rdata_d;
      end
      if (psel & penable & ~pready) begin
        pslverr <= (paddr[11:5] != 7'h00) || (paddr[1:0] != 2'b00);
      end
      if (wr_acc) begin
        case (paddr)
          `BMSD_ADDR_CTRL:   ctrl_q <= {pwdata[31:3], 1'b0, pwdata[1:0]};
          `BMSD_ADDR_MATCH:  match_q <= pwdata[31:2];
          `BMSD_ADDR_MASTER: master_addr_q <= pwdata[31:2];
          `BMSD_ADDR_BE:     be_q <= pwdata[3:0];
          `BMSD_ADDR_WDATA:  wdata_q <= pwdata;
          default:           ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      burst_read_enable_o  <= 1'b0;
      burst_write_enable_o <= 1'b0;
    end else begin
      burst_read_enable_o  <= brd_eff;
      burst_write_enable_o <= bwr_eff;
    end
  end
endmodule // bmsd_top

//--- tb/bmsd_chk.sv
`timescale 1ns/1ps
module bmsd_chk (
  input logic clk_sys_i,
  input logic rst_i,
  input logic test_port_select_strap_i,
  input logic bus_mode_strap_i,
  input logic burst_permit_strap_i,
  input logic bus_grant_in_i,
  input logic address_status_n_i,
  input logic mem_io_i,
  input logic data_ctrl_i,
  input logic test_mode_o,
  input logic generic_bus_o,
  input logic tck_oe_n_o,
  input logic tdi_oe_n_o,
  input logic burst_read_enable_o,
  input logic burst_write_enable_o,
  input logic bus_request_out_o,
  input logic address_status_n_o,
  input logic slave_hit_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic permit_q;
  always @(posedge clk_sys_i) begin
    if (rst_i) permit_q <= burst_permit_strap_i;
  end
  sequence s_grant;
    bus_request_out_o && $rose(bus_grant_in_i);
  endsequence
  a_test_mode_follow: assert property ($stable(test_port_select_strap_i)[*6] |->
    test_mode_o == test_port_select_strap_i) else $error("test mode wrong");
  a_bus_mode_follow: assert property ($stable(bus_mode_strap_i)[*6] |->
    generic_bus_o == bus_mode_strap_i) else $error("bus mode wrong");
  a_test_pins_in: assert property (test_mode_o[*3] |-> tck_oe_n_o && tdi_oe_n_o)
    else $error("test pins driven");
  a_irq_pins_out: assert property ((!test_mode_o)[*3] |-> !tck_oe_n_o)
    else $error("grant out not driven");
  a_burst_forced: assert property ((!generic_bus_o && !permit_q)[*3] |->
    !burst_read_enable_o && !burst_write_enable_o) else $error("burst not forced");
  a_ads_one_cycle: assert property ($fell(address_status_n_o) |=> address_status_n_o)
    else $error("address status too long");
  a_grant_to_ads: assert property (s_grant |-> ##[1:5] !address_status_n_o)
    else $error("no address status after grant");
  a_slave_hit_cause: assert property (slave_hit_o |->
    $past(!address_status_n_i && !mem_io_i && data_ctrl_i)) else $error("hit without data cycle");
endmodule // bmsd_chk

//--- tb/bmsd_arb_model.sv
`timescale 1ns/1ps
module bmsd_arb_model (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       req_i,
  input  wire [3:0] wait_i,
  output reg        gnt_o
);
  reg [3:0] cnt_q;
  // Grant a standing request after a wait
  always @(posedge clk_sys_i) begin
    if (rst_i || !req_i) begin
      cnt_q <= 4'h0;
      gnt_o <= 1'b0;
    end else if (cnt_q == wait_i) begin
      gnt_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // bmsd_arb_model

//--- tb/bus_mode_strap_decode_tb.sv
`timescale 1ns/1ps
module bus_mode_strap_decode_tb;
  logic clk_sys_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, e, h;
  logic test_port_select_strap_i = 0, bus_mode_strap_i = 0, burst_permit_strap_i = 0, tdo_src_i = 0;
  logic tck_pin_i = 0, tdi_pin_i = 0, tms_pin_i = 0, chain_grant_src_i = 0, irq_three_src_i = 0;
  logic irq_four_src_i = 0, address_status_n_i = 1, mem_io_i = 0, data_ctrl_i = 1, write_read_i = 0;
  logic [29:0] address_lines_i = 30'h0;
  logic [3:0] byte_lane_enables_i = 4'hf, wt = 4'h0, b;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, x, y;
  logic [2:0] m;
  int num_errors = 0, tests_run = 0, i, hits = 0;
  wire [31:0] prdata, data_lines_o;
  wire [29:0] address_lines_o;
  wire [3:0] byte_lane_enables_o, byte_lane_enables_oe_n_o;
  wire pready, pslverr, test_mode_o, generic_bus_o, reserved_cfg_o, tck_o, tck_oe_n_o, tdo_o, tdo_oe_n_o, tdi_o;
  wire tdi_oe_n_o, tms_o, tms_oe_n_o, chain_request_in_o, tck_in_o, tdi_in_o, tms_in_o, burst_read_enable_o;
  wire burst_write_enable_o, bus_request_out_o, address_lines_oe_n_o, address_status_n_o, address_status_oe_n_o;
  wire mem_io_o, data_ctrl_o, write_read_o, cycle_def_oe_n_o, data_lines_oe_n_o, slave_hit_o, bus_grant_in_i;
  bmsd_top dut_u (.*);
  bmsd_arb_model arb_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(bus_request_out_o), .wait_i(wt),
    .gnt_o(bus_grant_in_i));
  always #2 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    for (int k = 0; k < 4; k++) lane_mask[8*k+:8] = {8{!be[k] || (k < 2 && be[1:0] == 2'b11 && !be[k^2])}};
  endfunction
  function automatic logic [31:0] dup(input logic [3:0] be, input logic [31:0] d);
    return (be[1:0] == 2'b11 ? {d[31:16], d[31:16]} : d) & lane_mask(be);
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task report_and_stop;
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #40000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    x = $urandom(32'haad8);
    for (int s = 0; s < 9; s++) begin
      m = (s == 8) ? 3'b100 : 3'(s);
      {burst_permit_strap_i, bus_mode_strap_i, test_port_select_strap_i} <= m;
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      {tck_pin_i, tdi_pin_i, tms_pin_i, tdo_src_i, chain_grant_src_i, irq_three_src_i, irq_four_src_i} <= 7'($urandom);
      repeat (6) @(posedge clk_sys_i);
      if (s == 8) break;
      chk(test_mode_o, m[0]);
      chk(generic_bus_o, m[1]);
      chk(reserved_cfg_o, m[1] & m[2]);
      chk(tck_oe_n_o, m[0]);
      chk({tdo_oe_n_o, tdi_oe_n_o, tms_oe_n_o}, {!m[0], m[0], m[0]});
      if (m[0]) chk({tck_in_o, tdi_in_o, tms_in_o, tdo_o}, {tck_pin_i, tdi_pin_i, tms_pin_i, tdo_src_i});
      else chk({tck_o, tdi_o, tms_o, chain_request_in_o},
               {chain_grant_src_i, irq_three_src_i, irq_four_src_i, tdo_src_i});
      y = $urandom;
      apb(1'b1, 12'h000, {30'h0, y[1:0]});
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[1:0], (m[2:1] == 2'b00) ? 2'b00 : y[1:0]);
      chk({burst_write_enable_o, burst_read_enable_o}, (m[2:1] == 2'b00) ? 2'b00 : y[1:0]);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd[2:0], m);
      test_port_select_strap_i <= !m[0];
      repeat (6) @(posedge clk_sys_i);
      chk(test_mode_o, !m[0]);
    end
    $display("strap test done");
    for (i = 0; i < 16; i++) begin
      x = $urandom;
      y = $urandom;
      b = 4'(40'hedb7c93810 >> (4 * (i < 10 ? i : y % 10)));
      wt <= 4'(y >> 8);
      apb(1'b1, 12'h010, {28'h0, b});
      apb(1'b1, 12'h014, x);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd & lane_mask(b), dup(b, x));
      apb(1'b1, 12'h00c, {16{x[1:0]}});
      apb(1'b1, 12'h008, {16{x[1:0]}});
      apb(1'b1, 12'h000, {27'h0, x[4:3], 3'b100});
      while (address_status_n_o !== 1'b0) @(posedge clk_sys_i);
      chk({address_lines_o, data_ctrl_o, mem_io_o}, {{15{x[1:0]}}, 1'b1, x[4]});
      chk({write_read_o, byte_lane_enables_o}, {x[3], b});
      chk({bus_request_out_o, address_lines_oe_n_o, address_status_oe_n_o, cycle_def_oe_n_o,
           byte_lane_enables_oe_n_o}, 8'h80);
      @(posedge clk_sys_i);
      chk(data_lines_oe_n_o, !x[3]);
      if (x[3]) chk(data_lines_o & lane_mask(b), dup(b, x));
      repeat (2) @(posedge clk_sys_i);
      h = y[0] && !(y[1] & y[2]) && !(y[3] & y[4]);
      address_lines_i <= y[0] ? {15{x[1:0]}} : {15{~x[1:0]}};
      {mem_io_i, data_ctrl_i, write_read_i} <= {y[1] & y[2], !(y[3] & y[4]), y[5]};
      byte_lane_enables_i <= b;
      address_status_n_i <= 1'b0;
      @(posedge clk_sys_i);
      address_status_n_i <= 1'b1;
      address_lines_i <= ~address_lines_i;
      @(posedge clk_sys_i);
      hits += h;
      chk(slave_hit_o, h);
    end
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd, hits);
    $display("bus test done");
    apb(1'b0, 12'h020, 32'h0);
    chk({e, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, 12'h002, 32'h0);
    chk({e, rd[30:0]}, 32'h8000_0000);
    report_and_stop;
  end
endmodule // bus_mode_strap_decode_tb
bind bmsd_top bmsd_chk chk_u (.*);
